// file: dram_mode_pkg.sv
// constants for the dram mode and refresh control block
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus
package dram_mode_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [7:0] MODE_REG_OFFSET = 8'h7C;
  localparam logic [7:0] STATUS_REG_OFFSET = 8'h80;
  localparam logic [31:0] MODE_RESET = 32'h00440009;
  // software-writable bits: init, integrity, cmd rule, refresh rate, special mode
  localparam logic [31:0] MODE_RW_MASK = 32'h20310370;
  localparam int INIT_DONE_BIT = 29;
  localparam int INTEGRITY_LSB = 20;
  localparam int CMD_RULE_BIT = 16;
  localparam int RATE_LSB = 8;
  localparam int SPECIAL_LSB = 4;
  localparam logic [1:0] INTEGRITY_OFF = 2'h0;
  localparam logic [1:0] INTEGRITY_CHIPKILL = 2'h2;
  localparam logic [1:0] RATE_OFF = 2'h0;
  localparam logic [1:0] RATE_15US6 = 2'h1;
  localparam logic [1:0] RATE_7US8 = 2'h2;
  localparam logic [2:0] SPECIAL_SELF_REFRESH = 3'h0;
  localparam logic [2:0] SPECIAL_NOP = 3'h1;
  localparam logic [2:0] SPECIAL_NORMAL = 3'h7;
  localparam int REFRESH_15US6_PS = 15600000;
  localparam int REFRESH_7US8_PS = 7800000;
  localparam int REFRESH_64US_PS = 64000000;
  localparam logic [15:0] REFRESH_15US6_CYC = 16'(REFRESH_15US6_PS / CLK_PERIOD_PS);
  localparam logic [15:0] REFRESH_7US8_CYC = 16'(REFRESH_7US8_PS / CLK_PERIOD_PS);
  localparam logic [15:0] REFRESH_64US_CYC = 16'(REFRESH_64US_PS / CLK_PERIOD_PS);
  localparam logic [1:0] HOLD_1N = 2'h1;
  localparam logic [1:0] HOLD_2N = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
endpackage

// file: dram_mode_refresh_control.sv
// dram controller mode register, refresh timer, command hold and ecc gating
// assumes synchronous inputs on aclk and a well-behaved AXI4-Lite master
//
// Notes on behaviour
// [R1] software sets the init-done flag after bringing up the memory interface
// [R2] refresh only when init-done is set and the rate code is nonzero
// [R3] integrity code 00: no correction and no error logging
// [R4] integrity code 10: chip-kill checking with correction; 01 and 11 reserved
// [R5] command rule bit 0: address and ras/cas/we held two cycles
// [R6] command rule bit 1: address and ras/cas/we held one cycle
// [R7] rate code 00 disables refresh regardless of init-done
// [R8] rate codes 01/10/11 select 15.6, 7.8 and 64 microsecond intervals
// [R9] mode register resets to 0x00440009; reserved bits keep their default
// [R10] special mode 001 turns commands into nops, 111 normal, 000 self-refresh
// [R11] a counter times the interval and pulses a refresh request on expiry
`timescale 1ns/1ps
module dram_mode_refresh_control
  import dram_mode_pkg::*;
#(
  parameter logic [15:0] REFRESH_64US_CYCLES = REFRESH_64US_CYC
)
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic ce, // clock enable
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic cmd_valid, // core command offered
  output logic cmd_ready, // command taken
  input wire logic [12:0] cmd_addr, // command address
  input wire logic cmd_ras_n, // command ras
  input wire logic cmd_cas_n, // command cas
  input wire logic cmd_we_n, // command we
  output logic [12:0] mem_addr_bus, // memory address lines
  output logic mem_ras_n, // memory ras
  output logic mem_cas_n, // memory cas
  output logic mem_we_n, // memory we
  output logic mem_cmd_active, // command on the lines
  output logic mem_cke, // clock enable to devices
  output logic refresh_req, // refresh request pulse
  input wire logic ecc_err_in, // read data error seen
  output logic ecc_correct_en, // checking and correction on
  output logic err_log_pulse // error to first/next error log
);
  typedef struct packed {
    logic [31:0] mode;
    logic [15:0] cnt;
    logic refresh;
    logic [1:0] hold;
    logic [12:0] addr;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic correct;
    logic err_log;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wr_state_t wst;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_r, s_nxt;
  logic [1:0] rate, integrity;
  logic [2:0] special;
  logic init_done, cmd_rule, refresh_on, cmd_take;
  logic [15:0] limit;

  assign rate = s_r.mode[RATE_LSB +: 2];
  assign integrity = s_r.mode[INTEGRITY_LSB +: 2];
  assign special = s_r.mode[SPECIAL_LSB +: 3];
  assign init_done = s_r.mode[INIT_DONE_BIT];
  assign cmd_rule = s_r.mode[CMD_RULE_BIT];
  assign refresh_on = init_done && (rate != RATE_OFF); // [R2] [R7]
  assign limit = (rate == RATE_15US6) ? REFRESH_15US6_CYC :
                 (rate == RATE_7US8) ? REFRESH_7US8_CYC : REFRESH_64US_CYCLES; // [R8]

  assign s_axi_awready = ce && !s_r.aw_got && s_r.wst == WR_IDLE;
  assign s_axi_wready = ce && !s_r.w_got && s_r.wst == WR_IDLE;
  assign s_axi_bvalid = s_r.wst == WR_RESP;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = ce && !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign cmd_ready = ce && s_r.cke && s_r.hold <= HOLD_1N; // [R10]
  assign cmd_take = cmd_valid && cmd_ready;
  assign mem_addr_bus = s_r.addr;
  assign mem_ras_n = s_r.ras_n;
  assign mem_cas_n = s_r.cas_n;
  assign mem_we_n = s_r.we_n;
  assign mem_cmd_active = s_r.hold != 2'h0;
  assign mem_cke = s_r.cke;
  assign refresh_req = s_r.refresh;
  assign ecc_correct_en = s_r.correct;
  assign err_log_pulse = s_r.err_log;

  always_comb
  begin
    s_nxt = s_r;
    // refresh interval timer
    s_nxt.refresh = 1'b0;
    if (!refresh_on)
      s_nxt.cnt = 16'h0000;
    else if (s_r.cnt >= limit - 16'h0001)
    begin
      s_nxt.cnt = 16'h0000;
      s_nxt.refresh = 1'b1; // [R11]
    end
    else
      s_nxt.cnt = s_r.cnt + 16'h0001; // [R11]
    // command lines
    s_nxt.cke = special != SPECIAL_SELF_REFRESH; // [R10]
    if (s_r.hold != 2'h0)
      s_nxt.hold = s_r.hold - 2'h1;
    if (cmd_take)
    begin
      s_nxt.hold = cmd_rule ? HOLD_1N : HOLD_2N; // [R5] [R6]
      s_nxt.addr = cmd_addr;
      s_nxt.ras_n = cmd_ras_n || special == SPECIAL_NOP; // [R10]
      s_nxt.cas_n = cmd_cas_n || special == SPECIAL_NOP;
      s_nxt.we_n = cmd_we_n || special == SPECIAL_NOP;
    end
    else if (s_r.hold <= HOLD_1N)
    begin
      s_nxt.ras_n = 1'b1;
      s_nxt.cas_n = 1'b1;
      s_nxt.we_n = 1'b1;
    end
    // error handling gated by integrity mode
    s_nxt.correct = integrity == INTEGRITY_CHIPKILL; // [R4]
    s_nxt.err_log = ecc_err_in && integrity == INTEGRITY_CHIPKILL; // [R3] [R4]
    // register writes
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    case (s_r.wst)
      WR_IDLE:
        if (s_r.aw_got && s_r.w_got)
        begin
          s_nxt.aw_got = 1'b0;
          s_nxt.w_got = 1'b0;
          s_nxt.wst = WR_RESP;
          if (s_r.awaddr[7:2] == MODE_REG_OFFSET[7:2])
          begin
            s_nxt.bresp = RESP_OKAY;
            for (int i = 0; i < 4; i++)
              if (s_r.wstrb[i])
                s_nxt.mode[i*8 +: 8] = (s_r.wdata[i*8 +: 8] & MODE_RW_MASK[i*8 +: 8])
                  | (MODE_RESET[i*8 +: 8] & ~MODE_RW_MASK[i*8 +: 8]); // [R9]
          end
          else if (s_r.awaddr[7:2] == STATUS_REG_OFFSET[7:2])
            s_nxt.bresp = RESP_OKAY;
          else
            s_nxt.bresp = RESP_SLVERR;
        end
      WR_RESP:
        if (s_axi_bready)
          s_nxt.wst = WR_IDLE;
      default:
        s_nxt.wst = WR_IDLE;
    endcase
    // register reads
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      if (s_axi_araddr[7:2] == MODE_REG_OFFSET[7:2])
        s_nxt.rdata = s_r.mode;
      else if (s_axi_araddr[7:2] == STATUS_REG_OFFSET[7:2])
        s_nxt.rdata = {s_r.cnt, 12'h000, s_r.cke, mem_cmd_active, s_r.correct, refresh_on};
      else
      begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.mode <= MODE_RESET; // [R9]
      s_r.ras_n <= 1'b1;
      s_r.cas_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.wst <= WR_IDLE;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_drive_two;
    mem_cmd_active && !cmd_ready ##1 mem_cmd_active && $stable(mem_addr_bus);
  endsequence
  sequence s_drive_one;
    mem_cmd_active && cmd_ready;
  endsequence

  property p_refresh_needs_init;
    refresh_req |-> $past(init_done) && $past(rate) != RATE_OFF;
  endproperty
  a_refresh_needs_init: assert property (p_refresh_needs_init) // [R2]
    else $error("refresh without init-done or with rate off");
  property p_rate_off;
    rate == RATE_OFF |=> !refresh_req;
  endproperty
  a_rate_off: assert property (p_rate_off) // [R7]
    else $error("refresh with rate code zero");
  property p_no_log_off;
    integrity == INTEGRITY_OFF |=> !err_log_pulse && !ecc_correct_en;
  endproperty
  a_no_log_off: assert property (p_no_log_off) // [R3]
    else $error("error logged with integrity off");
  property p_chipkill_log;
    ecc_err_in && integrity == INTEGRITY_CHIPKILL |=> err_log_pulse && ecc_correct_en;
  endproperty
  a_chipkill_log: assert property (p_chipkill_log) // [R4]
    else $error("chip-kill error not logged");
  property p_two_cycle;
    cmd_take && !cmd_rule |=> s_drive_two;
  endproperty
  a_two_cycle: assert property (p_two_cycle) // [R5]
    else $error("2n command not held two cycles");
  property p_one_cycle;
    cmd_take && cmd_rule |=> s_drive_one;
  endproperty
  a_one_cycle: assert property (p_one_cycle) // [R6]
    else $error("1n command not released after one cycle");
  property p_reserved;
    (s_r.mode & ~MODE_RW_MASK) == (MODE_RESET & ~MODE_RW_MASK);
  endproperty
  a_reserved: assert property (p_reserved) // [R9]
    else $error("reserved mode bits changed");
  property p_nop_mode;
    cmd_take && special == SPECIAL_NOP |=> mem_ras_n && mem_cas_n && mem_we_n;
  endproperty
  a_nop_mode: assert property (p_nop_mode) // [R10]
    else $error("command not turned into nop");
  property p_self_refresh;
    special == SPECIAL_SELF_REFRESH |=> !mem_cke && !cmd_ready;
  endproperty
  a_self_refresh: assert property (p_self_refresh) // [R10]
    else $error("clock enable not dropped in self-refresh");
  property p_interval;
    refresh_on && rate == RATE_7US8 && s_r.cnt == REFRESH_7US8_CYC - 16'h0001
      && $stable(s_r.mode) |=> refresh_req && s_r.cnt == 16'h0000;
  endproperty
  a_interval: assert property (p_interval) // [R8] [R11]
    else $error("refresh not raised at interval end");
endmodule

// file: dram_device_model.sv
// behavioural ddr device on the command lines
// assumes a command is live while ras is low and cke is high
`timescale 1ns/1ps
module dram_device_model
(
  input wire logic aclk, // clock
  input wire logic cke, // clock enable from controller
  input wire logic ras_n, // row strobe
  output int hold_len, // cycles of the last command
  output int cmd_count // commands seen
);
  int run;
  initial
  begin
    run = 0;
    hold_len = 0;
    cmd_count = 0;
  end
  // length of each low run of ras, latched when it ends
  always @(posedge aclk)
  begin
    if (cke && !ras_n)
      run <= run + 1;
    else if (run != 0)
    begin
      hold_len <= run;
      cmd_count <= cmd_count + 1;
      run <= 0;
    end
  end
endmodule

// file: tb_dram_mode_refresh_control.sv
// self-checking bench for the dram mode and refresh control block
// assumes AXI4-Lite access to the mode register and a device model
`timescale 1ns/1ps
module tb_dram_mode_refresh_control;
  import dram_mode_pkg::*;
  typedef struct {logic init; logic [1:0] rate; int per;} ref_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_valid;
  logic cmd_ready, cmd_we_n, mem_ras_n, mem_cas_n, mem_we_n, mem_cmd_active, mem_cke;
  logic refresh_req, ecc_err_in, ecc_correct_en, err_log_pulse, ce;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] mem_addr_bus, cmd_addr;
  int hold_len, cmd_count, n, c;
  int fails = 0, checked = 0, cyc = 0;
  ref_row_t rows[5] = '{'{1'b0, 2'h1, 0}, '{1'b1, 2'h0, 0}, '{1'b1, 2'h1, 3120},
    '{1'b1, 2'h2, 1560}, '{1'b1, 2'h3, 64}};
  dram_mode_refresh_control #(.REFRESH_64US_CYCLES(16'h0040)) dram_mode_refresh_control_inst (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_ready, .cmd_addr,
    .cmd_ras_n(1'b0), .cmd_cas_n(cmd_we_n), .cmd_we_n, .mem_addr_bus, .mem_ras_n, .mem_cas_n,
    .mem_we_n, .mem_cmd_active, .mem_cke, .refresh_req, .ecc_err_in, .ecc_correct_en,
    .err_log_pulse);
  dram_device_model dram_device_model_inst (.aclk, .cke(mem_cke), .ras_n(mem_ras_n),
    .hold_len, .cmd_count);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] md(logic i, logic [1:0] g, logic k, logic [1:0] r,
    logic [2:0] s);
    return (32'(i) << 29) | (32'(g) << 20) | (32'(k) << 16) | (32'(r) << 8) | (32'(s) << 4);
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  // offers one command, then checks the lines one cycle after it is taken
  task automatic send_cmd(input logic nop);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    do
      @(posedge aclk);
    while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge aclk);
    chk("cmd addr", 32'(mem_addr_bus), 32'(cmd_addr));
    chk("cmd lines", 32'({mem_we_n, mem_cas_n, mem_cmd_active}),
      32'({{2{cmd_we_n | nop}}, 1'b1}));
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic wait_ref(input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (refresh_req !== 1'b1 && k < lim);
  endtask
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {cmd_valid, ecc_err_in, cmd_we_n, aresetn, ce} = 5'h05;
    cmd_addr = 13'h0ABC;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      axi_wr(MODE_REG_OFFSET, md(rows[i].init, 2'h0, 1'b0, rows[i].rate, 3'h7), 2'h0);
      wait_ref(4000, n);
      if (rows[i].per != 0)
        wait_ref(4000, n);
      chk("refresh period", 32'(n), 32'(rows[i].per == 0 ? 4000 : rows[i].per));
      $display("done refresh row %0d", i);
    end
    // every writable bit set except integrity bit 20, so integrity is chip-kill and not a reserved code
    axi_wr(MODE_REG_OFFSET, 32'hFFEFFFFF, 2'h0);
    axi_rd(MODE_REG_OFFSET, 32'h20650379, 2'h0);
    axi_wr(8'h00, 32'hFFFFFFFF, 2'h2);
    axi_rd(8'h00, 32'h00000000, 2'h2);
    $display("done register access");
    // freeze right after a refresh pulse: no pulse while frozen, full period after
    wait_ref(100, n);
    ce <= 1'b0;
    wait_ref(200, n);
    chk("frozen refresh", 32'(n), 32'h000000C8);
    chk("frozen readies", 32'({s_axi_awready, s_axi_wready, s_axi_arready, cmd_ready}), 32'h0);
    ce <= 1'b1;
    wait_ref(100, n);
    chk("resumed period", 32'(n), 32'h00000040);
    $display("done clock enable");
    for (c = 0; c < 2; c++)
    begin
      axi_wr(MODE_REG_OFFSET, md(1'b0, 2'h0, c[0], 2'h0, 3'h7), 2'h0);
      cmd_we_n <= c[0];
      cmd_addr <= c[0] ? 13'h1555 : 13'h0AAA;
      send_cmd(1'b0);
      chk("hold cycles", 32'(hold_len), 32'(2 - c));
      chk("cke", 32'(mem_cke), 32'h1);
    end
    n = cmd_count;
    axi_wr(MODE_REG_OFFSET, md(1'b0, 2'h0, 1'b1, 2'h0, 3'h1), 2'h0);
    cmd_we_n <= 1'b0;
    send_cmd(1'b1);
    chk("nop commands", 32'(cmd_count), 32'(n));
    axi_wr(MODE_REG_OFFSET, md(1'b0, 2'h0, 1'b1, 2'h0, 3'h0), 2'h0);
    repeat (2) @(posedge aclk);
    #1;
    chk("cke self refresh", 32'(mem_cke), 32'h0);
    chk("cmd refused", 32'(cmd_ready), 32'h0);
    $display("done command hold");
    for (c = 0; c < 2; c++)
    begin
      axi_wr(MODE_REG_OFFSET, md(1'b0, c[0] ? 2'h0 : 2'h2, 1'b1, 2'h0, 3'h7), 2'h0);
      @(posedge aclk);
      ecc_err_in <= 1'b1;
      #1;
      chk("correct enable", 32'(ecc_correct_en), 32'(c == 0));
      @(posedge aclk);
      ecc_err_in <= 1'b0;
      #1;
      chk("error log", 32'(err_log_pulse), 32'(c == 0));
    end
    $display("done integrity");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(MODE_REG_OFFSET, 32'h00440009, 2'h0);
    #1;
    chk("cke after reset", 32'(mem_cke), 32'h0);
    axi_rd(STATUS_REG_OFFSET, 32'h00000000, 2'h0);
    $display("done reset");
    end_sim();
  end
endmodule
